// [include/acs_cfg.svh]
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// Register byte offsets on the Wishbone slave.
`define ACS_ADR_CTRL 5'h00
`define ACS_ADR_RATE 5'h04
`define ACS_ADR_PITCH 5'h08
`define ACS_ADR_STATUS 5'h0C
`define ACS_ADR_ERRCNT 5'h10
`define ACS_ADR_SYNTH 5'h14
`define ACS_ADR_W 5

// Control register field positions.
`define ACS_CTRL_SRC_LSB 0
`define ACS_CTRL_SRC_MSB 2
`define ACS_CTRL_WCCLAMP 3
`define ACS_CTRL_AESIN 4
`define ACS_CTRL_CSFWD 5
`define ACS_CTRL_OPT2AES 6
`define ACS_CTRL_AESPRO 7
`define ACS_CTRL_CHAN_LSB 8
`define ACS_CTRL_CHAN_MSB 9
`define ACS_CTRL_RECPROC 10
`define ACS_CTRL_LOOPBACK 11

// Pitch register field positions.
`define ACS_PITCH_OFS_MSB 15
`define ACS_PITCH_PRE_LSB 16
`define ACS_PITCH_PRE_MSB 18

// Nominal rate reset value and width; error count ceiling.
`define ACS_NOMINAL_RESET 18'h0BB80
`define ACS_NOMINAL_W 18
`define ACS_ERR_MAX 16'hFFFF

// Pitch limits expressed as divisors of the nominal rate.
`define ACS_LIMIT_DIV 20'sd20
`define ACS_SMALL_DIV 20'sd1000
`define ACS_LARGE_DIV 20'sd25

// Word clock speed thresholds in Hz.
`define ACS_DOUBLE_MIN_HZ 20'sh124F8
`define ACS_QUAD_MIN_HZ 20'sh249F0

// Sample period thresholds in 20 ns clock cycles.
`define ACS_PER_MAX 12'hFFF
`define ACS_PER_NONE 12'h7D0
`define ACS_PER_32K 12'h544
`define ACS_PER_44K 12'h440
`define ACS_PER_48K 12'h324
`define ACS_PER_88K 12'h220
`define ACS_PER_96K 12'h192
`define ACS_PER_176K 12'h110
`define ACS_PER_192K 12'h0C8

`endif

// [include/acs_pkg.sv]
package acs_pkg;

typedef enum logic [2:0]
{
   ACS_SRC_INTERNAL = 3'b000,
   ACS_SRC_WORD = 3'b001,
   ACS_SRC_AES = 3'b010,
   ACS_SRC_OPT1 = 3'b011,
   ACS_SRC_OPT2 = 3'b100
} acs_source_type;

typedef enum logic [2:0]
{
   ACS_PRE_NONE = 3'b000,
   ACS_PRE_UP_SMALL = 3'b001,
   ACS_PRE_DOWN_SMALL = 3'b010,
   ACS_PRE_UP_LARGE = 3'b011,
   ACS_PRE_DOWN_LARGE = 3'b100
} acs_preset_type;

typedef enum logic [2:0]
{
   ACS_RATE_NONE = 3'b000,
   ACS_RATE_32K = 3'b001,
   ACS_RATE_44K = 3'b010,
   ACS_RATE_48K = 3'b011,
   ACS_RATE_88K = 3'b100,
   ACS_RATE_96K = 3'b101,
   ACS_RATE_176K = 3'b110,
   ACS_RATE_192K = 3'b111
} acs_rate_type;

typedef enum logic [1:0]
{
   ACS_IN_NONE = 2'b00,
   ACS_IN_LOCK = 2'b01,
   ACS_IN_SYNC = 2'b10
} acs_input_type;

typedef enum logic [1:0]
{
   ACS_CH_ALL = 2'b00,
   ACS_CH_NO_OPT2 = 2'b01,
   ACS_CH_ANALOG_AES = 2'b10,
   ACS_CH_ANALOG8 = 2'b11
} acs_chan_type;

typedef struct packed
{
   logic cyc;
   logic stb;
   logic we;
   logic [31:0] adr;
   logic [3:0] sel;
   logic [31:0] dat;
} acs_wb_req_type;

typedef struct packed
{
   logic aes_in_opt2;
   logic cs_forward;
   logic opt2_aes_mode;
   logic aes_pro;
   acs_chan_type chan_mode;
   logic record_path_processing;
   logic rec_use_output_proc;
} acs_route_type;

typedef struct packed
{
   logic ack;
   logic [31:0] rdat;
   acs_source_type src_sel;
   logic wc_clamp;
   logic loopback;
   acs_route_type route;
   logic [17:0] nominal;
   logic [15:0] offset;
   acs_preset_type preset;
   acs_source_type cur_src;
   logic [17:0] synth;
   logic [1:0] wclk_div;
   logic [15:0] err_cnt;
   logic [3:0][11:0] per_cnt;
   acs_rate_type [3:0] rate_class;
} acs_state_type;

endpackage

// [rtl/acs_clock_config.sv]
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "acs_cfg.svh"

module acs_clock_config
   import acs_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire acs_wb_req_type WB_REQ,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [3:0] SRC_LOCK,
   input wire logic [3:0] SRC_SYNC,
   input wire logic [3:0] SRC_TICK,
   input wire logic LINK_ERR,
   input wire logic SESSION_START,
   output acs_route_type ROUTE,
   output acs_source_type CUR_SOURCE,
   output logic [17:0] SYNTH_FREQ,
   output logic [1:0] WCLK_DIV
);

   acs_state_type state;
   acs_state_type next_state;

   // Byte lanes let the host change one field without reading first.
   function automatic logic [31:0] merge_bytes
   (
      input logic [31:0] old_word,
      input logic [31:0] new_word,
      input logic [3:0] sel
   );
      logic [31:0] result;
      result = old_word;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            result[i*8 +: 8] = new_word[i*8 +: 8];
         end
      end
      return result;
   endfunction

   // Thresholds sit midway between neighbouring standard periods.
   function automatic acs_rate_type classify(input logic [11:0] per);
      acs_rate_type r;
      if (per > `ACS_PER_NONE)
         r = ACS_RATE_NONE;
      else if (per > `ACS_PER_32K)
         r = ACS_RATE_32K;
      else if (per > `ACS_PER_44K)
         r = ACS_RATE_44K;
      else if (per > `ACS_PER_48K)
         r = ACS_RATE_48K;
      else if (per > `ACS_PER_88K)
         r = ACS_RATE_88K;
      else if (per > `ACS_PER_96K)
         r = ACS_RATE_96K;
      else if (per > `ACS_PER_176K)
         r = ACS_RATE_176K;
      else if (per >= `ACS_PER_192K)
         r = ACS_RATE_192K;
      else
         r = ACS_RATE_NONE;
      return r;
   endfunction

   function automatic acs_input_type input_state(input logic lock,
      input logic sync);
      acs_input_type s;
      if (!lock)
         s = ACS_IN_NONE;
      else if (sync)
         s = ACS_IN_SYNC;
      else
         s = ACS_IN_LOCK;
      return s;
   endfunction

   // Inputs are numbered from zero, while source codes start at one.
   function automatic logic [1:0] src_index(input acs_source_type src);
      logic [2:0] diff;
      diff = src - ACS_SRC_WORD;
      return diff[1:0];
   endfunction

   // Double and quad speed decide how far the base-rate clamp divides.
   function automatic logic [1:0] ext_speed(input acs_rate_type rc);
      logic [1:0] s;
      if (rc >= ACS_RATE_176K)
         s = 2'b10;
      else if (rc >= ACS_RATE_88K)
         s = 2'b01;
      else
         s = 2'b00;
      return s;
   endfunction

   logic [31:0] ctrl_word;
   logic [31:0] pitch_word;
   logic [31:0] status_word;
   logic [31:0] wmerged;
   logic [`ACS_ADR_W-1:0] adr;
   logic access;
   acs_source_type chosen;
   logic signed [19:0] nom_s;
   logic signed [19:0] limit;
   logic signed [19:0] ofs;
   logic signed [19:0] pull;
   logic signed [19:0] freq;
   logic [1:0] speed;

   always_comb
   begin
      // Register images are built once and shared by reads and by the
      // byte-lane merge of writes.
      ctrl_word = 32'h0;
      ctrl_word[`ACS_CTRL_SRC_MSB:`ACS_CTRL_SRC_LSB] = state.src_sel;
      ctrl_word[`ACS_CTRL_WCCLAMP] = state.wc_clamp;
      ctrl_word[`ACS_CTRL_AESIN] = state.route.aes_in_opt2;
      ctrl_word[`ACS_CTRL_CSFWD] = state.route.cs_forward;
      ctrl_word[`ACS_CTRL_OPT2AES] = state.route.opt2_aes_mode;
      ctrl_word[`ACS_CTRL_AESPRO] = state.route.aes_pro;
      ctrl_word[`ACS_CTRL_CHAN_MSB:`ACS_CTRL_CHAN_LSB] =
         state.route.chan_mode;
      ctrl_word[`ACS_CTRL_RECPROC] = state.route.record_path_processing;
      ctrl_word[`ACS_CTRL_LOOPBACK] = state.loopback;
      pitch_word = 32'h0;
      pitch_word[`ACS_PITCH_OFS_MSB:0] = state.offset;
      pitch_word[`ACS_PITCH_PRE_MSB:`ACS_PITCH_PRE_LSB] = state.preset;
      // Lock and sync are taken live at the request edge, so a read shows
      // the present input state rather than a latched one.
      status_word = {state.rate_class[3], state.rate_class[2],
         state.rate_class[1], state.rate_class[0], 4'h0,
         input_state(SRC_LOCK[3], SRC_SYNC[3]),
         input_state(SRC_LOCK[2], SRC_SYNC[2]),
         input_state(SRC_LOCK[1], SRC_SYNC[1]),
         input_state(SRC_LOCK[0], SRC_SYNC[0]),
         5'h00, state.cur_src};
   end

   always_comb
   begin
      next_state = state;
      adr = WB_REQ.adr[`ACS_ADR_W-1:0];
      // Upper address bits must be zero, so aliases of the map are
      // treated as unmapped.
      access = WB_REQ.cyc && WB_REQ.stb && !state.ack &&
         (WB_REQ.adr[31:`ACS_ADR_W] == '0);
      wmerged = 32'h0;

      // Ack follows one edge after the request; unmapped reads give zero.
      next_state.ack = WB_REQ.cyc && WB_REQ.stb && !state.ack;
      next_state.rdat = 32'h0;
      if (access && !WB_REQ.we)
      begin
         if (adr == `ACS_ADR_CTRL)
            next_state.rdat = ctrl_word;
         else if (adr == `ACS_ADR_RATE)
            next_state.rdat = {14'h0000, state.nominal};
         else if (adr == `ACS_ADR_PITCH)
            next_state.rdat = pitch_word;
         else if (adr == `ACS_ADR_STATUS)
            next_state.rdat = status_word;
         else if (adr == `ACS_ADR_ERRCNT)
            next_state.rdat = {16'h0000, state.err_cnt};
         else if (adr == `ACS_ADR_SYNTH)
            next_state.rdat = {14'h0000, state.synth};
      end

      // Writes land in the register set at once; no commit step exists.
      if (access && WB_REQ.we)
      begin
         if (adr == `ACS_ADR_CTRL)
         begin
            wmerged = merge_bytes(ctrl_word, WB_REQ.dat, WB_REQ.sel);
            next_state.src_sel = acs_source_type'(
               wmerged[`ACS_CTRL_SRC_MSB:`ACS_CTRL_SRC_LSB]);
            next_state.wc_clamp = wmerged[`ACS_CTRL_WCCLAMP];
            next_state.route.aes_in_opt2 = wmerged[`ACS_CTRL_AESIN];
            next_state.route.cs_forward = wmerged[`ACS_CTRL_CSFWD];
            next_state.route.opt2_aes_mode =
               wmerged[`ACS_CTRL_OPT2AES];
            next_state.route.aes_pro = wmerged[`ACS_CTRL_AESPRO];
            next_state.route.chan_mode = acs_chan_type'(
               wmerged[`ACS_CTRL_CHAN_MSB:`ACS_CTRL_CHAN_LSB]);
            next_state.route.record_path_processing =
               wmerged[`ACS_CTRL_RECPROC];
            next_state.loopback = wmerged[`ACS_CTRL_LOOPBACK];
         end
         else if (adr == `ACS_ADR_RATE)
         begin
            // Rate writes are not blocked while streaming; the host must.
            wmerged = merge_bytes({14'h0000, state.nominal}, WB_REQ.dat,
               WB_REQ.sel);
            next_state.nominal = wmerged[`ACS_NOMINAL_W-1:0];
         end
         else if (adr == `ACS_ADR_PITCH)
         begin
            // Coarse and fine steps are both plain writes of the offset.
            wmerged = merge_bytes(pitch_word, WB_REQ.dat, WB_REQ.sel);
            next_state.offset = wmerged[`ACS_PITCH_OFS_MSB:0];
            next_state.preset = acs_preset_type'(
               wmerged[`ACS_PITCH_PRE_MSB:`ACS_PITCH_PRE_LSB]);
         end
      end

      // An out-of-range source code is replaced by internal master at the next edge.
      if (state.src_sel > ACS_SRC_OPT2)
         next_state.src_sel = ACS_SRC_INTERNAL;
      next_state.route.rec_use_output_proc =
         state.route.record_path_processing && state.loopback;

      // Selected source wins while locked; otherwise scan in fixed order.
      // A fallback never overwrites the stored selection, so the chosen
      // input returns as soon as it locks again.
      chosen = ACS_SRC_INTERNAL;
      if (state.src_sel != ACS_SRC_INTERNAL &&
         state.src_sel <= ACS_SRC_OPT2 &&
         SRC_LOCK[src_index(state.src_sel)])
         chosen = state.src_sel;
      else if (state.src_sel != ACS_SRC_INTERNAL)
      begin
         if (SRC_LOCK[0])
            chosen = ACS_SRC_WORD;
         else if (SRC_LOCK[1])
            chosen = ACS_SRC_AES;
         else if (SRC_LOCK[2])
            chosen = ACS_SRC_OPT1;
         else if (SRC_LOCK[3])
            chosen = ACS_SRC_OPT2;
      end
      next_state.cur_src = chosen;

      // Period measurement per input, one tick per sample.
      // A saturated counter marks the input silent, so a lost signal
      // drops to no rate instead of keeping a stale class.
      for (int i = 0; i < 4; i++)
      begin
         if (SRC_TICK[i])
         begin
            next_state.rate_class[i] = classify(state.per_cnt[i] +
               12'h001);
            next_state.per_cnt[i] = 12'h000;
         end
         else if (state.per_cnt[i] != `ACS_PER_MAX)
            next_state.per_cnt[i] = state.per_cnt[i] + 12'h001;
         else
            next_state.rate_class[i] = ACS_RATE_NONE;
      end

      // Offset is clamped to the 5 percent window before presets add.
      nom_s = signed'({2'b00, state.nominal});
      limit = nom_s / `ACS_LIMIT_DIV;
      ofs = {{4{state.offset[15]}}, state.offset};
      if (ofs > limit)
         ofs = limit;
      else if (ofs < -limit)
         ofs = -limit;
      // Presets truncate toward zero, so the pull may be short by less than one hertz
      // for rates that are not multiples of the divisor.
      case (state.preset)
         ACS_PRE_UP_SMALL: pull = nom_s / `ACS_SMALL_DIV;
         ACS_PRE_DOWN_SMALL: pull = -(nom_s / `ACS_SMALL_DIV);
         ACS_PRE_UP_LARGE: pull = nom_s / `ACS_LARGE_DIV;
         ACS_PRE_DOWN_LARGE: pull = -(nom_s / `ACS_LARGE_DIV);
         default: pull = 20'sh00000;
      endcase
      if (state.cur_src == ACS_SRC_INTERNAL)
         freq = nom_s + ofs + pull;
      else
         freq = nom_s;
      next_state.synth = freq[17:0];

      // Speed of the running rate decides the base-rate divider.
      speed = 2'b00;
      if (state.cur_src == ACS_SRC_INTERNAL)
      begin
         if (freq >= `ACS_QUAD_MIN_HZ)
            speed = 2'b10;
         else if (freq >= `ACS_DOUBLE_MIN_HZ)
            speed = 2'b01;
      end
      else
         speed = ext_speed(state.rate_class[src_index(state.cur_src)]);
      if (state.wc_clamp)
         next_state.wclk_div = speed;
      else
         next_state.wclk_div = 2'b00;

      // An error in the starting cycle still counts.
      // The count saturates rather than wraps, so a long session never
      // reads back as error free.
      if (SESSION_START)
         next_state.err_cnt = {15'h0000, LINK_ERR};
      else if (LINK_ERR && state.err_cnt != `ACS_ERR_MAX)
         next_state.err_cnt = state.err_cnt + 16'h0001;
   end

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         // Only the nominal rate leaves reset with a non-zero value.
         state <= '0;
         state.nominal <= `ACS_NOMINAL_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign WB_DAT_O = state.rdat;
   assign WB_ACK_O = state.ack;
   assign ROUTE = state.route;
   assign CUR_SOURCE = state.cur_src;
   assign SYNTH_FREQ = state.synth;
   assign WCLK_DIV = state.wclk_div;

endmodule

// [verif/acs_clock_config_checker.sv]
`timescale 1ns/100ps
module acs_clock_config_checker
   import acs_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire acs_wb_req_type WB_REQ,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic [3:0] SRC_LOCK,
   input wire logic [3:0] SRC_SYNC,
   input wire logic [3:0] SRC_TICK,
   input wire logic LINK_ERR,
   input wire logic SESSION_START,
   input wire acs_route_type ROUTE,
   input wire acs_source_type CUR_SOURCE,
   input wire logic [17:0] SYNTH_FREQ,
   input wire logic [1:0] WCLK_DIV
);
   logic [3:0] lock_q;
   logic take;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   assign take = WB_REQ.cyc & WB_REQ.stb & !WB_ACK_O;
   always_ff @(posedge CLOCK or negedge RSTN)
      if (!RSTN)
         lock_q <= 4'h0;
      else
         lock_q <= SRC_LOCK;
   property p_ack; take |=> WB_ACK_O; endproperty
   a_ack: assert property (p_ack) else $error("request not acked");
   property p_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_pulse: assert property (p_pulse) else $error("ack held");
   property p_nolock; SRC_LOCK == 4'h0 |=> CUR_SOURCE == ACS_SRC_INTERNAL;
   endproperty
   a_nolock: assert property (p_nolock) else $error("no fallback");
   property p_inuse;
      CUR_SOURCE != ACS_SRC_INTERNAL |-> lock_q[CUR_SOURCE - 3'h1];
   endproperty
   a_inuse: assert property (p_inuse) else $error("unlocked source");
   property p_range; CUR_SOURCE <= ACS_SRC_OPT2; endproperty
   a_range: assert property (p_range) else $error("bad source");
   property p_status;
      WB_ACK_O && !$past(WB_REQ.we) && $past(WB_REQ.adr) == 32'hC
         |-> WB_DAT_O[2:0] == $past(CUR_SOURCE);
   endproperty
   a_status: assert property (p_status) else $error("status source");
   property p_synth;
      (CUR_SOURCE != ACS_SRC_INTERNAL && !WB_REQ.cyc) [*3]
         |-> $stable(SYNTH_FREQ);
   endproperty
   a_synth: assert property (p_synth) else $error("offset in slave");
   property p_route;
      take && WB_REQ.we && WB_REQ.adr == 32'h0 && WB_REQ.sel == 4'hF
         |=> ##1 ROUTE.cs_forward == $past(WB_REQ.dat[5], 2)
         && ROUTE.chan_mode == $past(WB_REQ.dat[9:8], 2);
   endproperty
   a_route: assert property (p_route) else $error("route stale");
   property p_rec;
      ROUTE.rec_use_output_proc |-> $past(ROUTE.record_path_processing);
   endproperty
   a_rec: assert property (p_rec) else $error("loopback path");
endmodule

bind acs_clock_config acs_clock_config_checker acs_clock_config_checker_i
(
   .CLOCK(CLOCK), .RSTN(RSTN), .WB_REQ(WB_REQ), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .SRC_LOCK(SRC_LOCK), .SRC_SYNC(SRC_SYNC),
   .SRC_TICK(SRC_TICK), .LINK_ERR(LINK_ERR),
   .SESSION_START(SESSION_START), .ROUTE(ROUTE), .CUR_SOURCE(CUR_SOURCE),
   .SYNTH_FREQ(SYNTH_FREQ), .WCLK_DIV(WCLK_DIV)
);

// [verif/acs_host.sv]
`timescale 1ns/100ps
module acs_host
   import acs_pkg::*;
#(
   parameter int SETTLE = 8
)
(
   input wire logic CLOCK,
   input wire logic [31:0] DAT,
   input wire logic ACK,
   input wire logic STREAMING,
   output acs_wb_req_type REQ
);
   logic [31:0] rdat;
   logic [15:0] pitch;
   initial
   begin
      REQ = '0;
      pitch = 16'h0000;
   end
   task automatic cycle(input logic we, input logic [31:0] a,
                        input logic [31:0] d, input logic [3:0] s);
      @(posedge CLOCK);
      REQ <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
      do
         @(posedge CLOCK);
      while (ACK !== 1'b1);
      rdat = DAT;
      REQ <= '0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      cycle(1'b1, a, d, 4'hF);
   endtask
   task automatic wrb(input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      cycle(1'b1, a, d, s);
   endtask
   task automatic rd(input logic [31:0] a);
      cycle(1'b0, a, 32'h0, 4'hF);
   endtask
   // SETTLE stands in for the long settling time after a rate change.
   task automatic set_rate(input logic [17:0] hz);
      if (STREAMING !== 1'b1)
      begin
         wr(32'h4, {14'h0, hz});
         repeat (SETTLE) @(posedge CLOCK);
      end
   endtask
   task automatic coarse(input logic up);
      pitch = up ? pitch + 16'h0032 : pitch - 16'h0032;
      wr(32'h8, {16'h0, pitch});
   endtask
endmodule

// [verif/tb_top.sv]
`timescale 1ns/100ps
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top
   import acs_pkg::*;
;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic lerr = 1'b0;
   logic sstart = 1'b0;
   logic streaming = 1'b0;
   logic [3:0] lock = 4'h0;
   logic [3:0] sync = 4'h0;
   logic [3:0] tick = 4'h0;
   acs_wb_req_type req;
   logic [31:0] dat;
   logic ack;
   acs_route_type route;
   acs_source_type cur;
   logic [17:0] synth;
   logic [1:0] wdiv;
   int errors = 0;
   int check_count = 0;
   always #10 clock = ~clock;
   acs_clock_config acs_clock_config_i
   (
      .CLOCK(clock), .RSTN(rstn), .WB_REQ(req), .WB_DAT_O(dat),
      .WB_ACK_O(ack), .SRC_LOCK(lock), .SRC_SYNC(sync), .SRC_TICK(tick),
      .LINK_ERR(lerr), .SESSION_START(sstart), .ROUTE(route),
      .CUR_SOURCE(cur), .SYNTH_FREQ(synth), .WCLK_DIV(wdiv)
   );
   acs_host acs_host_i
   (
      .CLOCK(clock), .DAT(dat), .ACK(ack), .STREAMING(streaming), .REQ(req)
   );
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic synth_is(input logic [31:0] pitch, input logic [17:0] e);
      acs_host_i.wr(32'h8, pitch);
      acs_host_i.rd(32'h14);
      `CHK(acs_host_i.rdat, e);
   endtask
   task automatic see(input logic [3:0] l, input logic [2:0] e);
      @(posedge clock);
      lock <= l;
      acs_host_i.rd(32'hC);
      `CHK(acs_host_i.rdat[2:0], e);
   endtask
   task automatic t_pitch;
      acs_host_i.rd(32'h4);
      `CHK(acs_host_i.rdat, 32'h0000BB80);
      acs_host_i.wrb(32'h4, 32'hFFFF00AA, 4'h1);
      acs_host_i.rd(32'h4);
      `CHK(acs_host_i.rdat, 32'h0000BBAA);
      acs_host_i.wrb(32'h4, 32'h12345680, 4'h1);
      acs_host_i.rd(32'h4);
      `CHK(acs_host_i.rdat, 32'h0000BB80);
      acs_host_i.rd(32'h20);
      `CHK(acs_host_i.rdat, 32'h0);
      synth_is(32'h00000064, 18'h0BBE4);
      synth_is(32'h00000BB8, 18'h0C4E0);
      synth_is(32'h00030000, 18'h0C300);
      synth_is(32'h00020000, 18'h0BB50);
      synth_is(32'h00010000, 18'h0BBB0);
      synth_is(32'h00040000, 18'h0B400);
      synth_is(32'h0000F448, 18'h0B220);
      synth_is(32'h00000000, 18'h0BB80);
      acs_host_i.coarse(1'b0);
      acs_host_i.rd(32'h14);
      `CHK(acs_host_i.rdat, 32'h0000BB4E);
   endtask
   task automatic t_source;
      acs_host_i.wr(32'h0, 32'h2);
      see(4'b0000, 3'h0);
      see(4'b0110, 3'h2);
      `CHK(synth, 18'h0BB80);
      see(4'b0100, 3'h3);
      see(4'b1101, 3'h1);
      see(4'b1000, 3'h4);
      @(posedge clock);
      sync <= 4'b1101;
      see(4'b0110, 3'h2);
      `CHK(acs_host_i.rdat[15:8], 8'h24);
      @(posedge clock);
      sync <= 4'b0010;
      see(4'b0110, 3'h2);
      `CHK(acs_host_i.rdat[15:8], 8'h18);
      acs_host_i.wr(32'h0, 32'h0);
      see(4'b0110, 3'h0);
   endtask
   task automatic t_rate;
      for (int n = 0; n < 3200; n++)
      begin
         @(posedge clock);
         tick <= {n % 260 == 0, n % 521 == 0, n % 1134 == 0, n % 1042 == 0};
      end
      @(posedge clock);
      tick <= 4'h0;
      lock <= 4'b1000;
      acs_host_i.rd(32'hC);
      `CHK(acs_host_i.rdat[31:20], 12'hF53);
      acs_host_i.wr(32'h0, 32'hC);
      repeat (3) @(posedge clock);
      `CHK(cur, ACS_SRC_OPT2);
      `CHK(wdiv, 2'b10);
      repeat (4100) @(posedge clock);
      acs_host_i.rd(32'hC);
      `CHK(acs_host_i.rdat[31:20], 12'h000);
      acs_host_i.wr(32'h0, 32'h0);
   endtask
   task automatic t_wclk;
      @(posedge clock);
      streaming <= 1'b1;
      @(posedge clock);
      acs_host_i.set_rate(18'h17700);
      streaming <= 1'b0;
      acs_host_i.rd(32'h4);
      `CHK(acs_host_i.rdat, 32'h0000BB80);
      acs_host_i.wr(32'h8, 32'h0);
      acs_host_i.set_rate(18'h17700);
      acs_host_i.wr(32'h0, 32'h8);
      repeat (3) @(posedge clock);
      `CHK(wdiv, 2'b01);
      acs_host_i.set_rate(18'h2EE00);
      `CHK(wdiv, 2'b10);
      acs_host_i.wr(32'h0, 32'h0);
      repeat (3) @(posedge clock);
      `CHK(wdiv, 2'b00);
      acs_host_i.set_rate(18'h0BB80);
   endtask
   task automatic t_route;
      logic [1:0] m;
      for (int i = 0; i < 4; i++)
      begin
         m = 2'(i);
         acs_host_i.wr(32'h0, {20'h0, m[0], 1'b1, m, {4{m[0]}}, 4'h0});
         repeat (3) @(posedge clock);
         `CHK(route, {{4{m[0]}}, m, 1'b1, m[0]});
      end
      acs_host_i.wr(32'h0, 32'h0);
   endtask
   task automatic t_err;
      repeat (3)
      begin
         @(posedge clock);
         lerr <= 1'b1;
         @(posedge clock);
         lerr <= 1'b0;
      end
      acs_host_i.rd(32'h10);
      `CHK(acs_host_i.rdat, 32'h3);
      @(posedge clock);
      sstart <= 1'b1;
      @(posedge clock);
      sstart <= 1'b0;
      acs_host_i.rd(32'h10);
      `CHK(acs_host_i.rdat, 32'h0);
      @(posedge clock);
      lerr <= 1'b1;
      sstart <= 1'b1;
      @(posedge clock);
      lerr <= 1'b0;
      sstart <= 1'b0;
      acs_host_i.rd(32'h10);
      `CHK(acs_host_i.rdat, 32'h1);
   endtask
   initial
   begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      t_pitch();
      t_source();
      t_rate();
      t_wclk();
      t_route();
      t_err();
      conclude();
   end
   // The run needs about 7500 cycles; the limit leaves a wide margin.
   initial
   begin
      repeat (40000) @(posedge clock);
      errors++;
      conclude();
   end
endmodule
